// file: ssc_pkg.sv
// Constants shared by the synchronous client serial port.
// Assumes an Avalon-MM master with 32-bit data and byte addresses.
package ssc_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [3:0] SSC_CTRL_OFS = 4'h0;
  localparam logic [3:0] SSC_STAT_OFS = 4'h4;
  localparam logic [3:0] SSC_TXD_OFS = 4'h8;
  localparam logic [3:0] SSC_RXD_OFS = 4'hc;

  // Control register layout
  localparam int SSC_CTRL_W = 13;
  localparam int CTL_SERIAL_PORT_ENABLE = 0;   // serial_port_enable
  localparam int CTL_SYNC = 1;   // clocked mode select
  localparam int CTL_CLOCK_SOURCE_HOST = 2;   // clock_source_host
  localparam int CTL_TRANSMIT_ENABLE = 3;   // transmit_enable
  localparam int CTL_SINGLE_RECEIVE_ENABLE = 4;   // single_receive_enable
  localparam int CTL_CONTINUOUS_RECEIVE_ENABLE = 5;   // continuous_receive_enable
  localparam int CTL_TX9 = 6;    // nine_bit_transmit_enable
  localparam int CTL_RX9 = 7;    // nine_bit_receive_enable
  localparam int CTL_CLOCK_POLARITY_BIT = 8;   // clock_polarity_bit
  localparam int CTL_TRANSMIT_NINTH_BIT = 9;   // transmit_ninth_bit
  localparam int CTL_TXIE = 10;  // transmit_interrupt_enable
  localparam int CTL_RXIE = 11;  // receive_interrupt_enable
  localparam int CTL_PERIPHERAL_INTERRUPT_ENABLE = 12;  // peripheral_interrupt_enable
  localparam logic [SSC_CTRL_W-1:0] SSC_CTRL_RST = 13'h0000;

  // Status register layout
  localparam int ST_TXF = 0;     // transmit_flag
  localparam int ST_RXF = 1;     // receive_flag
  localparam int ST_OVR = 2;     // overrun_flag
  localparam int ST_TEMPTY = 3;  // transmit shift register empty
  localparam int ST_RECEIVE_NINTH_BIT = 4;    // receive_ninth_bit of top entry
  localparam int ST_HFULL = 5;   // holding register occupied

  // Character sizes and receive FIFO depth
  localparam logic [3:0] SSC_BITS8 = 4'h8;
  localparam logic [3:0] SSC_BITS9 = 4'h9;
  localparam logic [1:0] SSC_FIFO_FULL = 2'h2;

  // Reset values of flags and the bus handshake
  localparam logic SSC_TXF_RST = 1'b1;
  localparam logic SSC_WAIT_RST = 1'b1;

endpackage

// file: ssc_port.sv
// Synchronous client serial port with an Avalon-MM register slave.
// Assumes the external host drives the bit clock on clock_line_pin and
// data_line_pin is resolved from data_line_out/data_line_oe by the pad.
`timescale 1ns/100ps
`default_nettype none

module ssc_port
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Avalon-MM register slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Serial link pins
  input wire logic clock_line_pin,
  input wire logic data_line_in,
  output logic data_line_out,
  output logic data_line_oe,
  // Wake request towards the core
  output logic wake_request
);

  // Whole state of the port in one record
  typedef struct packed {
    logic [1:0] clk_sync;          // Clock pin synchroniser
    logic [1:0] dat_sync;          // Data pin synchroniser
    logic clk_last;                // Previous synchronised clock level
    logic [SSC_CTRL_W-1:0] ctrl;   // Control bits
    logic [7:0] hold_data;         // Holding register low byte
    logic hold_ninth;              // Holding register ninth bit
    logic hold_full;               // Holding register occupied
    logic [8:0] tx_shift;          // Transmit shift register
    logic [3:0] tx_left;           // Bits still to present
    logic tx_busy;                 // Shift register not empty
    logic tx_flag;                 // Holding register free
    logic data_out;                // Driven data level
    logic data_oe;                 // Data pin driven
    logic [8:0] rx_shift;          // Receive shift register
    logic [3:0] rx_got;            // Bits received so far
    logic [1:0][8:0] fifo;         // Two-entry receive FIFO
    logic fifo_head;               // Index of the top entry
    logic [1:0] fifo_cnt;          // Entries held
    logic overrun;                 // Overrun flag
    logic wake;                    // Wake request
    logic wait_req;                // Avalon waitrequest
    logic [31:0] rdata;            // Avalon readdata
  } ssc_state_type;

  ssc_state_type state_reg;
  ssc_state_type state_next;

  // Decoded helpers shared with the assertions
  logic client_mode;
  logic tx_dir;
  logic lead_edge;
  logic trail_edge;
  logic bus_take;
  logic [3:0] rx_bits;
  logic [8:0] rx_word;

  // Client mode decode and link edge detection from synchronised levels
  always_comb begin
    client_mode = state_reg.ctrl[CTL_SERIAL_PORT_ENABLE] & state_reg.ctrl[CTL_SYNC]
                  & ~state_reg.ctrl[CTL_CLOCK_SOURCE_HOST];
    // Either receive enable turns the port round to receive
    tx_dir = ~state_reg.ctrl[CTL_SINGLE_RECEIVE_ENABLE] & ~state_reg.ctrl[CTL_CONTINUOUS_RECEIVE_ENABLE];
    // Leading edge leaves the idle level, trailing edge returns to it
    lead_edge = (state_reg.clk_last == state_reg.ctrl[CTL_CLOCK_POLARITY_BIT])
                & (state_reg.clk_sync[1] != state_reg.ctrl[CTL_CLOCK_POLARITY_BIT]);
    trail_edge = (state_reg.clk_last != state_reg.ctrl[CTL_CLOCK_POLARITY_BIT])
                 & (state_reg.clk_sync[1] == state_reg.ctrl[CTL_CLOCK_POLARITY_BIT]);
    bus_take = (read | write) & ~state_reg.wait_req;
    rx_bits = state_reg.ctrl[CTL_RX9] ? SSC_BITS9 : SSC_BITS8;
    // Eight-bit words sit in the top of the shifter, so drop the stale bit
    rx_word = {state_reg.dat_sync[1], state_reg.rx_shift[8:1]};
    if (!state_reg.ctrl[CTL_RX9]) begin
      rx_word = {1'b0, rx_word[8:1]};
    end
  end

  // Next-state logic of bus, transmitter and receiver
  always_comb begin
    state_next = state_reg;
    // Two flops per pin; only the second stage is looked at
    state_next.clk_sync = {state_reg.clk_sync[0], clock_line_pin};
    state_next.dat_sync = {state_reg.dat_sync[0], data_line_in};
    state_next.clk_last = state_reg.clk_sync[1];

    // Bus: answer one cycle after a request is seen, then release
    if ((read | write) && state_reg.wait_req) begin
      state_next.wait_req = 1'b0;
      unique case (address)
        SSC_CTRL_OFS: state_next.rdata = 32'(state_reg.ctrl);
        SSC_STAT_OFS: begin
          state_next.rdata = 32'h0;
          state_next.rdata[ST_TXF] = state_reg.tx_flag;
          state_next.rdata[ST_RXF] = state_reg.fifo_cnt != 2'h0;
          state_next.rdata[ST_OVR] = state_reg.overrun;
          state_next.rdata[ST_TEMPTY] = ~state_reg.tx_busy;
          state_next.rdata[ST_RECEIVE_NINTH_BIT] = state_reg.fifo[state_reg.fifo_head][8];
          state_next.rdata[ST_HFULL] = state_reg.hold_full;
        end
        SSC_RXD_OFS: state_next.rdata = 32'(state_reg.fifo[state_reg.fifo_head][7:0]);
        default: state_next.rdata = 32'h0;  // Transmit data and holes read zero
      endcase
    end else begin
      state_next.wait_req = SSC_WAIT_RST;
    end

    // Control register write
    if (bus_take && write && address == SSC_CTRL_OFS) begin
      state_next.ctrl = writedata[SSC_CTRL_W-1:0];
    end

    // Transmit: present next bit on each leading edge of the host clock
    if (client_mode && tx_dir && state_reg.tx_busy && lead_edge
        && state_reg.tx_left != 4'h0) begin
      state_next.data_out = state_reg.tx_shift[0];
      state_next.tx_shift = {1'b0, state_reg.tx_shift[8:1]};
      state_next.tx_left = state_reg.tx_left - 4'h1;
    end
    // Last bit is held until the host samples it on the trailing edge
    if (client_mode && tx_dir && state_reg.tx_busy && trail_edge
        && state_reg.tx_left == 4'h0) begin
      state_next.tx_busy = 1'b0;
    end
    // Writing the holding register frees nothing yet, so the flag drops
    if (bus_take && write && address == SSC_TXD_OFS) begin
      state_next.hold_data = writedata[7:0];
      state_next.hold_ninth = state_reg.ctrl[CTL_TRANSMIT_NINTH_BIT];
      state_next.hold_full = 1'b1;
      state_next.tx_flag = 1'b0;
    end
    // Empty shifter takes the held word at once; the flag set wins a clear
    if (!state_next.tx_busy && state_next.hold_full) begin
      state_next.tx_shift = {state_next.hold_ninth, state_next.hold_data};
      state_next.tx_left = state_reg.ctrl[CTL_TX9] ? SSC_BITS9 : SSC_BITS8;
      state_next.tx_busy = 1'b1;
      state_next.hold_full = 1'b0;
      state_next.tx_flag = 1'b1;
    end
    // Pin is driven only when configured to transmit in client mode
    state_next.data_oe = client_mode & state_reg.ctrl[CTL_TRANSMIT_ENABLE] & tx_dir;

    // Receive data read pops the top entry
    if (bus_take && read && address == SSC_RXD_OFS && state_reg.fifo_cnt != 2'h0) begin
      state_next.fifo_head = ~state_reg.fifo_head;
      state_next.fifo_cnt = state_reg.fifo_cnt - 2'h1;
    end
    // Receive: sample on trailing edges; single receive enable plays no part
    if (client_mode && state_reg.ctrl[CTL_CONTINUOUS_RECEIVE_ENABLE] && !state_reg.overrun
        && trail_edge) begin
      state_next.rx_shift = {state_reg.dat_sync[1], state_reg.rx_shift[8:1]};
      state_next.rx_got = state_reg.rx_got + 4'h1;
      if (state_reg.rx_got + 4'h1 == rx_bits) begin
        state_next.rx_got = 4'h0;
        if (state_next.fifo_cnt == SSC_FIFO_FULL) begin
          state_next.overrun = 1'b1;
        end else begin
          // Whole word moves from the shifter into the FIFO
          state_next.fifo[state_next.fifo_head ^ state_next.fifo_cnt[0]] = rx_word;
          state_next.fifo_cnt = state_next.fifo_cnt + 2'h1;
        end
      end
    end
    // Dropping continuous receive discards any partial word and the overrun
    if (!state_reg.ctrl[CTL_CONTINUOUS_RECEIVE_ENABLE] || !client_mode) begin
      state_next.rx_got = 4'h0;
      state_next.overrun = 1'b0;
    end
    // Port disable holds the transmitter and receive FIFO in reset
    if (!state_reg.ctrl[CTL_SERIAL_PORT_ENABLE]) begin
      state_next.hold_full = 1'b0;
      state_next.tx_busy = 1'b0;
      state_next.tx_left = 4'h0;
      state_next.tx_flag = SSC_TXF_RST;
      state_next.fifo_cnt = 2'h0;
      state_next.fifo_head = 1'b0;
      state_next.data_out = 1'b0;
    end

    // Wake request from the flags and their enables
    state_next.wake = (state_next.tx_flag & state_reg.ctrl[CTL_TXIE]
                       & state_reg.ctrl[CTL_PERIPHERAL_INTERRUPT_ENABLE])
                      | ((state_next.fifo_cnt != 2'h0) & state_reg.ctrl[CTL_RXIE]);
  end

  // State register; reset gives constants only
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.ctrl <= SSC_CTRL_RST;
      state_reg.tx_flag <= SSC_TXF_RST;
      state_reg.wait_req <= SSC_WAIT_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign readdata = state_reg.rdata;
  assign waitrequest = state_reg.wait_req;
  assign data_line_out = state_reg.data_out;
  assign data_line_oe = state_reg.data_oe;
  assign wake_request = state_reg.wake;

  // Pin driven implies receive enables were clear the cycle before
  a_txdir_oe_off: assert property (@(posedge mclk) disable iff (reset)
    data_line_oe |-> $past(!state_reg.ctrl[CTL_SINGLE_RECEIVE_ENABLE] && !state_reg.ctrl[CTL_CONTINUOUS_RECEIVE_ENABLE]
                           && client_mode))
    else $error("data pin driven while receive enabled");

  // Taking a word into a busy shifter leaves the flag clear
  a_write_clears_flag: assert property (@(posedge mclk) disable iff (reset)
    (bus_take && write && address == SSC_TXD_OFS && state_reg.tx_busy
     && !(trail_edge && state_reg.tx_left == 4'h0) && state_reg.ctrl[CTL_SERIAL_PORT_ENABLE])
    |=> !state_reg.tx_flag && state_reg.hold_full)
    else $error("transmit flag not cleared by holding write");

  // Drained shifter with a pending word reloads and sets the flag
  a_drain_reload: assert property (@(posedge mclk) disable iff (reset)
    (client_mode && tx_dir && state_reg.tx_busy && trail_edge
     && state_reg.tx_left == 4'h0 && state_reg.hold_full)
    |=> state_reg.tx_busy && state_reg.tx_flag && !state_reg.hold_full)
    else $error("pending word not moved to shifter");

  // Data pin level changes only after a host leading edge
  a_shift_on_edge: assert property (@(posedge mclk) disable iff (reset)
    ($changed(data_line_out) && $past(state_reg.ctrl[CTL_SERIAL_PORT_ENABLE]))
    |-> $past(lead_edge))
    else $error("data changed without a host clock edge");

  // Standing flag with both enables gives a wake; a holding write may clear it first
  a_tx_wake: assert property (@(posedge mclk) disable iff (reset)
    (state_reg.tx_flag && state_reg.ctrl[CTL_TXIE] && state_reg.ctrl[CTL_PERIPHERAL_INTERRUPT_ENABLE]
     && $stable(state_reg.ctrl) && !(bus_take && write && address == SSC_TXD_OFS))
    |=> ##[0:1] wake_request)
    else $error("transmit wake missing");

  // Overrun keeps the FIFO fill level from rising
  a_overrun_hold: assert property (@(posedge mclk) disable iff (reset)
    (state_reg.overrun && state_reg.ctrl[CTL_CONTINUOUS_RECEIVE_ENABLE] && state_reg.ctrl[CTL_SERIAL_PORT_ENABLE])
    |=> state_reg.fifo_cnt <= $past(state_reg.fifo_cnt))
    else $error("character accepted during overrun");

  // Clearing continuous receive removes the overrun next cycle
  a_overrun_clear: assert property (@(posedge mclk) disable iff (reset)
    !state_reg.ctrl[CTL_CONTINUOUS_RECEIVE_ENABLE] |=> !state_reg.overrun)
    else $error("overrun survived receive disable");

  // A completed word is counted into an empty FIFO
  a_rx_push: assert property (@(posedge mclk) disable iff (reset)
    (client_mode && state_reg.ctrl[CTL_CONTINUOUS_RECEIVE_ENABLE] && !state_reg.overrun && trail_edge
     && state_reg.rx_got + 4'h1 == rx_bits && state_reg.fifo_cnt == 2'h0)
    |=> state_reg.fifo_cnt == 2'h1
        && state_reg.fifo[state_reg.fifo_head] == $past(rx_word))
    else $error("received word not stored");

  // Bus request answered in the next cycle
  a_bus_answer: assert property (@(posedge mclk) disable iff (reset)
    ((read || write) && waitrequest) |=> !waitrequest)
    else $error("bus request not answered");

endmodule // ssc_port

`default_nettype wire

// file: ssc_host_model.sv
// Behavioural external host for the client port: owns the bit clock and data.
// Assumes the bench calls park and frame; the clock stands still between frames.
`timescale 1ns/100ps
`default_nettype none
module ssc_host_model (
  // Setting from the bench
  input wire logic polarity,
  // Port side of the data pin
  input wire logic dev_data,
  input wire logic dev_oe,
  // Lines the host drives
  output logic bit_clk,
  output logic host_data
);
  // Quiet lines at time zero
  initial begin
    bit_clk = 1'b0;
    host_data = 1'b0;
  end
  // Idle clock level follows the polarity setting
  // Level comes as an argument: the polarity port may not have settled yet
  task automatic park(input logic lvl);
    bit_clk <= lvl;
  endtask
  // One character, one clock cycle per bit, LSB first, nothing extra
  task automatic frame(input int nbits, input logic [8:0] send, output logic [8:0] got);
    got = '0;
    for (int i = 0; i < nbits; i++) begin
      bit_clk <= ~polarity; // Leading edge, host changes its data
      host_data <= send[i];
      #40 bit_clk <= polarity; // Trailing edge, port samples here
      #35 got[i] = dev_oe ? dev_data : 1'bx; // Port bit stands until next leading edge
      #5;
    end
    host_data <= ~host_data; // Released line must not show a stale bit
    #100;
  endtask
endmodule // ssc_host_model
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the synchronous client serial port.
// Assumes the port answers each bus request after one cycle and a host model.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ssc_pkg::*;
  // Bench drives, port answers
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic pol = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q;
  logic waitrequest, data_line_out, data_line_oe, wake_request, clk_pin, host_data;
  logic [8:0] got;
  int err_total = 0;
  int n_tests = 0;
  // One ordinary case: direction, control word, character
  typedef struct {logic rx; logic [12:0] ctl; logic [8:0] val;} ssc_row_type;
  ssc_row_type rows [4] = '{'{1'b0, 13'h00b, 9'h0a5}, '{1'b0, 13'h34b, 9'h13c},
                            '{1'b1, 13'h123, 9'h05a}, '{1'b1, 13'h0a3, 9'h1c3}};
  always #5 mclk = ~mclk;
  ssc_port i_ssc_port (.mclk(mclk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .clock_line_pin(clk_pin), .data_line_in(host_data), .data_line_out(data_line_out),
    .data_line_oe(data_line_oe), .wake_request(wake_request));
  ssc_host_model i_ssc_host_model (.polarity(pol), .dev_data(data_line_out),
    .dev_oe(data_line_oe), .bit_clk(clk_pin), .host_data(host_data));
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    // Only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Read one status bit and compare it
  task automatic stb(input int b, input logic exp, input string nm);
    bus(1'b0, SSC_STAT_OFS, 32'h0);
    chk(nm, {31'h0, exp}, {31'h0, q[b]});
  endtask
  // Disable, park the host clock, enable the client, then the full setting
  task automatic setup(input logic [12:0] ctl);
    bus(1'b1, SSC_CTRL_OFS, 32'h0);
    pol = ctl[CTL_CLOCK_POLARITY_BIT];
    i_ssc_host_model.park(ctl[CTL_CLOCK_POLARITY_BIT]);
    bus(1'b1, SSC_CTRL_OFS, {19'h0, ctl & 13'h103});
    bus(1'b1, SSC_CTRL_OFS, {19'h0, ctl});
    // Pin enable is registered from the stored control word
    repeat (2) @(posedge mclk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog well beyond the expected run of about twelve microseconds
  initial begin
    #300000;
    err_total++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    bus(1'b0, SSC_CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'h0, q);
    stb(ST_TXF, 1'b1, "tx flag reset");
    bus(1'b1, 4'h2, 32'hffff);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    // Ordinary transfers in both directions, both polarities, 8 and 9 bits
    foreach (rows[i]) begin
      setup(rows[i].ctl);
      chk("oe", {31'h0, ~rows[i].rx}, {31'h0, data_line_oe});
      if (!rows[i].rx) begin
        bus(1'b1, SSC_TXD_OFS, {24'h0, rows[i].val[7:0]});
        i_ssc_host_model.frame(rows[i].ctl[CTL_TX9] ? 9 : 8, 9'h0, got);
        chk("tx word", {23'h0, rows[i].val}, {23'h0, got});
      end else begin
        i_ssc_host_model.frame(rows[i].ctl[CTL_RX9] ? 9 : 8, rows[i].val, got);
        stb(ST_RXF, 1'b1, "rx flag");
        stb(ST_RECEIVE_NINTH_BIT, rows[i].val[8], "rx ninth");
        bus(1'b0, SSC_RXD_OFS, 32'h0);
        chk("rx byte", {24'h0, rows[i].val[7:0]}, q);
      end
    end
    // Holding register and transmit flag across back-to-back writes
    setup(13'h140b);
    bus(1'b1, SSC_TXD_OFS, 32'h61);
    bus(1'b1, SSC_TXD_OFS, 32'h62);
    stb(ST_TXF, 1'b0, "tx flag held");
    stb(ST_HFULL, 1'b1, "holding full");
    chk("wake held", 32'h0, {31'h0, wake_request});
    i_ssc_host_model.frame(8, 9'h0, got);
    chk("first word", 32'h61, {23'h0, got});
    stb(ST_TXF, 1'b1, "tx flag reload");
    chk("wake tx", 32'h1, {31'h0, wake_request});
    bus(1'b1, SSC_TXD_OFS, 32'h63);
    stb(ST_TXF, 1'b0, "tx flag write");
    chk("wake cleared", 32'h0, {31'h0, wake_request});
    i_ssc_host_model.frame(8, 9'h0, got);
    chk("second word", 32'h62, {23'h0, got});
    i_ssc_host_model.frame(8, 9'h0, got);
    chk("third word", 32'h63, {23'h0, got});
    stb(ST_TEMPTY, 1'b1, "shifter empty");
    // Host clock source selected: not a client, nothing received
    setup(13'h027);
    i_ssc_host_model.frame(8, 9'h055, got);
    stb(ST_RXF, 1'b0, "host source rx");
    // Single receive enable alone does nothing in client mode
    setup(13'h813);
    i_ssc_host_model.frame(8, 9'h011, got);
    stb(ST_RXF, 1'b0, "single enable rx");
    // Fill the FIFO, overrun on the third, stall, then clear
    bus(1'b1, SSC_CTRL_OFS, 32'h833);
    i_ssc_host_model.frame(8, 9'h011, got);
    chk("wake rx", 32'h1, {31'h0, wake_request});
    i_ssc_host_model.frame(8, 9'h022, got);
    i_ssc_host_model.frame(8, 9'h033, got);
    stb(ST_OVR, 1'b1, "overrun");
    i_ssc_host_model.frame(8, 9'h044, got);
    bus(1'b0, SSC_RXD_OFS, 32'h0);
    chk("fifo first", 32'h11, q);
    bus(1'b0, SSC_RXD_OFS, 32'h0);
    chk("fifo second", 32'h22, q);
    stb(ST_RXF, 1'b0, "fifo drained");
    bus(1'b1, SSC_CTRL_OFS, 32'h813);
    stb(ST_OVR, 1'b0, "overrun cleared");
    // Mid-run reset returns control and flags to their reset values
    @(posedge mclk);
    reset <= 1'b1;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    bus(1'b0, SSC_CTRL_OFS, 32'h0);
    chk("ctrl mid reset", 32'h0, q);
    stb(ST_TXF, 1'b1, "tx flag mid reset");
    chk("oe mid reset", 32'h0, {31'h0, data_line_oe});
    final_report();
  end
endmodule // testbench
`default_nettype wire
